/* bench/sad_target_model.sv */
`default_nettype none
module sad_target_model (
  input wire logic clk, // system clock
  input wire logic [6:0] tgt_sel, // one-hot select
  input wire logic [31:0] tgt_addr, // offset inside region
  output logic [5:0][31:0] rd // read data, one word per target
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] sel_q;
  always_ff @(posedge clk) sel_q <= tgt_sel[5:0];
  // answers while selected and one cycle after; otherwise junk, so a late sample shows
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      rd[k] = {3'(k), tgt_addr[28:0]};
      if (!(tgt_sel[k] | sel_q[k])) rd[k] = ~rd[k];
    end
  end
endmodule
`default_nettype wire

/* bench/tb_system_address_decoder.sv */
`default_nettype none
module tb_system_address_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] W1 = 4'h1;
  localparam logic [3:0] W2 = 4'h3;
  typedef struct {logic [31:0] d; time t; int lat;} sad_note_t;
  logic clk = 1'b0, reset = 1'b1, req = 1'b0, we = 1'b0, boot_sel_wr = 1'b0, ready, tgt_we;
  logic [1:0] boot_pins = 2'h0, boot_sel = 2'h0, boot_map;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, tgt_addr, tgt_wdata;
  logic [3:0] be = 4'h0, tgt_be;
  logic [6:0] tgt_sel;
  logic [5:0][31:0] trd;
  sad_note_t notes[$];
  sad_note_t cur;
  int n_mismatch = 0, total_checks = 0, seed = 96388;

  sad_decoder #(.BR1_WAIT(W1), .BR2_WAIT(W2)) sad_decoder_i (.clk(clk), .reset(reset),
    .boot_pins(boot_pins), .boot_sel(boot_sel), .boot_sel_wr(boot_sel_wr), .req(req),
    .we(we), .addr(addr), .be(be), .wdata(wdata), .ready(ready), .rdata(rdata),
    .tgt_sel(tgt_sel), .tgt_we(tgt_we), .tgt_addr(tgt_addr), .tgt_be(tgt_be),
    .tgt_wdata(tgt_wdata), .tgt_rdata_ram(trd[0]), .tgt_rdata_flash(trd[1]),
    .tgt_rdata_ext(trd[2]), .tgt_rdata_prc(trd[3]), .tgt_rdata_br1(trd[4]),
    .tgt_rdata_br2(trd[5]), .boot_map(boot_map));
  sad_target_model sad_target_model_i (.clk(clk), .tgt_sel(tgt_sel), .tgt_addr(tgt_addr),
    .rd(trd));

  initial forever #10 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // -1 means no target; region 0 follows the current boot alias
  function automatic int tgt_of(input logic [2:0] r, input logic [1:0] b);
    if (r == 3'h0) return (b == 2'h1) ? 0 : (b == 2'h2) ? 2 : 1;
    if (r == 3'h4) return -1;
    return (r < 3'h4) ? int'(r) - 1 : int'(r) - 2;
  endfunction

  task automatic access(input logic w, input logic [31:0] a);
    int t;
    logic [31:0] d, exp;
    logic [3:0] bm;
    t = tgt_of(a[31:29], boot_map);
    d = $random(seed);
    bm = 4'($random(seed));
    exp = (w || t < 0) ? 32'h0 : {3'(t), a[28:0]};
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    be <= bm;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    notes.push_back('{exp, $time, (t == 4) ? W1 + 4 : (t == 5) ? W2 + 4 : 2});
    @(negedge clk);
    check({25'h0, tgt_sel}, (t < 0) ? 32'h0 : 32'h1 << t, "select");
    if (t >= 0) begin
      check(tgt_addr, {3'h0, a[28:0]}, "offset");
      check(tgt_wdata, d, "write data");
      check({27'h0, tgt_we, tgt_be}, {27'h0, w, bm}, "lanes");
    end
    for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clk);
    check({31'h0, ready}, 32'h1, "ready timeout");
  endtask

  task automatic do_reset(input logic [1:0] p);
    @(posedge clk);
    boot_pins <= p;
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic set_boot(input logic [1:0] v, input logic [1:0] exp);
    @(posedge clk);
    boot_sel <= v;
    boot_sel_wr <= 1'b1;
    @(posedge clk);
    boot_sel_wr <= 1'b0;
    @(negedge clk);
    check({30'h0, boot_map}, {30'h0, exp}, "boot select");
  endtask

  always @(posedge clk) begin
    if (ready === 1'b1) begin
      if (notes.size() == 0) check(32'h1, 32'h0, "unexpected ready");
      else begin
        cur = notes.pop_front();
        check(rdata, cur.d, "read data");
        check(32'(($time - cur.t) / 20), 32'(cur.lat), "latency");
      end
    end
  end

  initial begin
    for (int p = 0; p < 4; p++) begin
      do_reset(2'(p));
      check({30'h0, boot_map}, 32'(p), "strap");
      access(1'b0, {3'h0, 29'($random(seed))});
    end
    for (int r = 0; r < 8; r++) begin
      access(1'b0, {3'(r), 29'($random(seed))});
      access(1'b1, {3'(r), 29'($random(seed))});
    end
    access(1'b0, 32'hFFFF_FFFC);
    set_boot(2'h1, 2'h1);
    access(1'b0, 32'h0000_0100);
    set_boot(2'h3, 2'h1);
    set_boot(2'h2, 2'h2);
    access(1'b0, 32'h0000_0040);
    repeat (10) @(posedge clk);
    check(32'(notes.size()), 32'h0, "missing ready");
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire

/* rtl/sad_decoder.sv */
`include "sad_regs.svh"
`default_nettype none
// How it works
// - top three address bits pick region
// - one flat 4 GByte address space
// - little-endian byte lanes on all accesses
// - bridge accesses stall core with wait states
// - region bases fixed at eight 512M steps
// - native targets direct, peripherals via bridges
// - boot region aliases strap-chosen target
// - software remaps boot alias at run time
module sad_decoder #(
  parameter logic [3:0] BR1_WAIT = `SAD_BR_WAIT_DEFAULT, // extra cycles on bridge 1
  parameter logic [3:0] BR2_WAIT = `SAD_BR_WAIT_DEFAULT // extra cycles on bridge 2
) (
  input wire logic clk, // system clock
  input wire logic reset, // sync reset, active high
  input wire logic [1:0] boot_pins, // boot straps, from pins
  input wire logic [1:0] boot_sel, // run-time boot select field
  input wire logic boot_sel_wr, // pulse: load boot_sel
  input wire logic req, // core access request
  input wire logic we, // write when high
  input wire logic [31:0] addr, // byte address
  input wire logic [3:0] be, // byte enables, lane 0 = lowest address
  input wire logic [31:0] wdata, // write data
  output logic ready, // pulse: access complete
  output logic [31:0] rdata, // read data
  output logic [6:0] tgt_sel, // one-hot target select
  output logic tgt_we, // write to target
  output logic [31:0] tgt_addr, // offset inside region
  output logic [3:0] tgt_be, // target byte enables
  output logic [31:0] tgt_wdata, // target write data
  input wire logic [31:0] tgt_rdata_ram, // read data from ram
  input wire logic [31:0] tgt_rdata_flash, // read data from flash
  input wire logic [31:0] tgt_rdata_ext, // read data from external_memory_interface
  input wire logic [31:0] tgt_rdata_prc, // read data from power_reset_clock_unit
  input wire logic [31:0] tgt_rdata_br1, // read data from bridge 1
  input wire logic [31:0] tgt_rdata_br2, // read data from bridge 2
  output logic [1:0] boot_map // current boot alias
);
  logic [1:0] pins_m_q, pins_s_q;
  logic strap_pend_q, strap_pend_d;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic [1:0] boot_q, boot_d;
  sad_pkg::sad_state_t st_q, st_d;
  sad_pkg::sad_target_t tgt_q, tgt_d, dec;
  logic ready_q, ready_d;
  logic [31:0] rdata_q, rdata_d;
  logic [6:0] sel_q, sel_d;
  logic we_q, we_d;
  logic [31:0] taddr_q, taddr_d;
  logic [3:0] tbe_q, tbe_d;
  logic [31:0] twd_q, twd_d;
  logic tmr_start;
  logic [3:0] tmr_count;
  logic tmr_exp;
  logic [2:0] region;

  // straps sampled through two flops, caught once after reset release
  always_ff @(posedge clk) begin
    if (reset) begin
      pins_m_q <= 2'h0;
      pins_s_q <= 2'h0;
    end else begin
      pins_m_q <= boot_pins;
      pins_s_q <= pins_m_q;
    end
  end

  always_comb begin
    boot_d = boot_q;
    strap_cnt_d = strap_cnt_q;
    if (strap_cnt_q != `SAD_STRAP_SETTLED) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
    end
    strap_pend_d = (strap_cnt_q == `SAD_STRAP_LOAD);
    if (strap_pend_q) begin
      boot_d = pins_s_q;
    end else if (boot_sel_wr && boot_sel != `SAD_BOOTSEL_KEEP) begin
      boot_d = boot_sel;
    end
  end

  // strap pending is set for one cycle, two cycles after release, so the sync chain has filled
  always_ff @(posedge clk) begin
    if (reset) begin
      boot_q <= `SAD_BOOTSEL_FLASH;
      strap_cnt_q <= 2'h0;
      strap_pend_q <= 1'b0;
    end else begin
      boot_q <= boot_d;
      strap_cnt_q <= strap_cnt_d;
      strap_pend_q <= strap_pend_d;
    end
  end

  always_comb begin
    region = addr[`SAD_REGION_MSB:`SAD_REGION_LSB];
    case (region)
      `SAD_REG_BOOT: begin
        case (boot_q)
          `SAD_BOOTSEL_RAM: dec = sad_pkg::SAD_T_RAM;
          `SAD_BOOTSEL_EXT: dec = sad_pkg::SAD_T_EXT;
          default: dec = sad_pkg::SAD_T_FLASH;
        endcase
      end
      `SAD_REG_RAM: dec = sad_pkg::SAD_T_RAM;
      `SAD_REG_FLASH: dec = sad_pkg::SAD_T_FLASH;
      `SAD_REG_EXT: dec = sad_pkg::SAD_T_EXT;
      `SAD_REG_PRC: dec = sad_pkg::SAD_T_PRC;
      `SAD_REG_BR1: dec = sad_pkg::SAD_T_BR1;
      `SAD_REG_BR2: dec = sad_pkg::SAD_T_BR2;
      default: dec = sad_pkg::SAD_T_NONE;
    endcase
  end

  always_comb begin
    st_d = st_q;
    tgt_d = tgt_q;
    ready_d = 1'b0;
    rdata_d = rdata_q;
    sel_d = sel_q;
    we_d = we_q;
    taddr_d = taddr_q;
    tbe_d = tbe_q;
    twd_d = twd_q;
    tmr_start = 1'b0;
    tmr_count = 4'h0;
    case (st_q)
      sad_pkg::SAD_IDLE: begin
        if (req) begin
          tgt_d = dec;
          we_d = we;
          // offset keeps low 29 bits; lanes pass straight, lane 0 = LSB
          taddr_d = {3'h0, addr[`SAD_REGION_LSB-1:0]};
          tbe_d = be;
          twd_d = wdata;
          sel_d = (dec == sad_pkg::SAD_T_NONE) ? 7'h00 : 7'(7'h01 << dec);
          if (dec == sad_pkg::SAD_T_BR1 || dec == sad_pkg::SAD_T_BR2) begin
            tmr_start = 1'b1;
            tmr_count = (dec == sad_pkg::SAD_T_BR1) ? BR1_WAIT : BR2_WAIT;
            st_d = sad_pkg::SAD_WAIT;
          end else begin
            st_d = sad_pkg::SAD_DONE;
          end
        end
      end
      sad_pkg::SAD_WAIT: begin
        if (tmr_exp) begin
          st_d = sad_pkg::SAD_DONE;
        end
      end
      sad_pkg::SAD_DONE: begin
        ready_d = 1'b1;
        sel_d = 7'h00;
        st_d = sad_pkg::SAD_IDLE;
        case (tgt_q)
          sad_pkg::SAD_T_RAM: rdata_d = tgt_rdata_ram;
          sad_pkg::SAD_T_FLASH: rdata_d = tgt_rdata_flash;
          sad_pkg::SAD_T_EXT: rdata_d = tgt_rdata_ext;
          sad_pkg::SAD_T_PRC: rdata_d = tgt_rdata_prc;
          sad_pkg::SAD_T_BR1: rdata_d = tgt_rdata_br1;
          sad_pkg::SAD_T_BR2: rdata_d = tgt_rdata_br2;
          default: rdata_d = 32'h00000000;
        endcase
        if (we_q) begin
          rdata_d = 32'h00000000;
        end
      end
      default: st_d = sad_pkg::SAD_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= sad_pkg::SAD_IDLE;
      tgt_q <= sad_pkg::SAD_T_NONE;
      ready_q <= 1'b0;
      rdata_q <= 32'h00000000;
      sel_q <= 7'h00;
      we_q <= 1'b0;
      taddr_q <= 32'h00000000;
      tbe_q <= 4'h0;
      twd_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      tgt_q <= tgt_d;
      ready_q <= ready_d;
      rdata_q <= rdata_d;
      sel_q <= sel_d;
      we_q <= we_d;
      taddr_q <= taddr_d;
      tbe_q <= tbe_d;
      twd_q <= twd_d;
    end
  end

  sad_wait_timer #(.W(4)) u_wait (
    .clk(clk),
    .reset(reset),
    .start(tmr_start),
    .count(tmr_count),
    .expired(tmr_exp)
  );

  assign ready = ready_q;
  assign rdata = rdata_q;
  assign tgt_sel = sel_q;
  assign tgt_we = we_q;
  assign tgt_addr = taddr_q;
  assign tgt_be = tbe_q;
  assign tgt_wdata = twd_q;
  assign boot_map = boot_q;

  rsvd_quiet_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == sad_pkg::SAD_IDLE && req && addr[31:29] == 3'h4) |=>
      tgt_sel == 7'h00 ##1 (ready && rdata == 32'h00000000))
    else $error("reserved access reached a target or read nonzero");
  ram_decode_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == sad_pkg::SAD_IDLE && req && addr[31:29] == 3'h1) |=> tgt_sel == 7'h01)
    else $error("ram region not selected");
  prc_decode_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == sad_pkg::SAD_IDLE && req && addr[31:29] == 3'h5) |=> tgt_sel == 7'h08)
    else $error("power unit not selected directly");
  offset_pass_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == sad_pkg::SAD_IDLE && req) |=> tgt_addr == {3'h0, $past(addr[28:0])})
    else $error("region offset wrong");
  lanes_pass_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == sad_pkg::SAD_IDLE && req) |=> (tgt_be == $past(be) && tgt_wdata == $past(wdata)))
    else $error("byte lanes reordered");
  br_stall_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == sad_pkg::SAD_IDLE && req && addr[31:29] == 3'h6) |=> !ready [*4])
    else $error("bridge access finished too early");
  native_fast_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == sad_pkg::SAD_IDLE && req && addr[31:29] == 3'h2) |-> ##2 ready)
    else $error("native access not done in two cycles");
  boot_alias_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == sad_pkg::SAD_IDLE && req && addr[31:29] == 3'h0 && boot_q == 2'h1)
      |=> tgt_sel == 7'h01)
    else $error("boot alias not routed to ram");
  boot_remap_a: assert property (@(posedge clk) disable iff (reset)
    (!strap_pend_q && boot_sel_wr && boot_sel == 2'h1) |=> boot_map == 2'h1)
    else $error("run-time boot remap ignored");
endmodule
`default_nettype wire

/* rtl/sad_pkg.sv */
`default_nettype none
package sad_pkg;
  typedef enum logic [2:0] {
    SAD_T_RAM, SAD_T_FLASH, SAD_T_EXT, SAD_T_PRC, SAD_T_BR1, SAD_T_BR2, SAD_T_NONE
  } sad_target_t;
  typedef enum {SAD_IDLE, SAD_WAIT, SAD_DONE} sad_state_t;
endpackage
`default_nettype wire

/* rtl/sad_regs.svh */
`ifndef SAD_REGS_SVH
`define SAD_REGS_SVH
`define SAD_REGION_MSB 31
`define SAD_REGION_LSB 29
`define SAD_REG_BOOT 3'h0
`define SAD_REG_RAM 3'h1
`define SAD_REG_FLASH 3'h2
`define SAD_REG_EXT 3'h3
`define SAD_REG_RSVD 3'h4
`define SAD_REG_PRC 3'h5
`define SAD_REG_BR1 3'h6
`define SAD_REG_BR2 3'h7
`define SAD_BASE_BOOT 32'h00000000
`define SAD_BASE_RAM 32'h20000000
`define SAD_BASE_FLASH 32'h40000000
`define SAD_BASE_EXT 32'h60000000
`define SAD_BASE_PRC 32'hA0000000
`define SAD_BASE_BR1 32'hC0000000
`define SAD_BASE_BR2 32'hE0000000
`define SAD_BOOTSEL_FLASH 2'h0
`define SAD_BOOTSEL_RAM 2'h1
`define SAD_BOOTSEL_EXT 2'h2
`define SAD_BOOTSEL_KEEP 2'h3
`define SAD_BR_WAIT_DEFAULT 4'h2
`define SAD_STRAP_LOAD 2'h1
`define SAD_STRAP_SETTLED 2'h3
`endif

/* rtl/sad_wait_timer.sv */
`include "sad_regs.svh"
`default_nettype none
module sad_wait_timer #(
  parameter int W = 4
) (
  input wire logic clk, // system clock
  input wire logic reset, // sync reset
  input wire logic start, // load the count
  input wire logic [W-1:0] count, // wait states to insert
  output logic expired // pulse when count ran out
);
  logic [W-1:0] cnt_q, cnt_d;
  logic run_q, run_d;
  logic exp_q, exp_d;
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    if (start) begin
      cnt_d = count;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end
  assign expired = exp_q;
endmodule
`default_nettype wire
